// >>> fch_ctrl.sv
// Host-side controller for an asynchronous byte-wide blocked flash.
// Assumes an AXI4-Lite master on aclk and flash pins outside this clock domain.
//
// How it works
// - Program and erase need two ordered writes.
// - No read before 400 ns wake.
// - No command write before 1 us wake.
// - Program zero only into changing bits.
// - Read-array command before reading array again.
// - Read with select, output enable low.
// - Identifier command then address zero or one.
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module fch_ctrl (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [7:0]         awaddr,
    input  wire logic [2:0]         awprot,
    input  wire logic               awvalid,
    output wire logic               awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output wire logic               wready,
    output logic      [1:0]         bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [7:0]         araddr,
    input  wire logic [2:0]         arprot,
    input  wire logic               arvalid,
    output wire logic               arready,
    output logic      [31:0]        rdata,
    output logic      [1:0]         rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    output fch_pkg::fch_pins_s      flash_pins,
    input  wire logic [7:0]         data_bus_in,
    input  wire logic               ready_busy_n
);
    import fch_pkg::*;

    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = (a == REG_CTRL) || (a == REG_ADDR) || (a == REG_WDATA) ||
                     (a == REG_POWER) || (a == REG_STATUS) || (a == REG_RDATA);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old & ~m) | (nw & m);
    endfunction

    // Step table: kind and command byte per operation and step
    function automatic logic [10:0] step_info(input fch_op_e op, input logic [2:0] i);
        logic [10:0] s;
        s = {K_END, 8'h00};
        case (op)
            OP_READ:        if (i == 3'd0) s = {K_RD, 8'h00};
            OP_READ_ARRAY:  if (i == 3'd0) s = {K_CMD, CMD_READ_ARRAY};
                            else if (i == 3'd1) s = {K_RD, 8'h00};
            OP_READ_STATUS: if (i == 3'd0) s = {K_CMD, CMD_READ_STATUS};
                            else if (i == 3'd1) s = {K_RD, 8'h00};
            OP_READ_ID:     if (i == 3'd0) s = {K_CMD, CMD_READ_ID};
                            else if (i == 3'd1) s = {K_RD, 8'h00};
            OP_PROGRAM:     case (i)
                                3'd0:    s = {K_CMD, CMD_READ_ARRAY};
                                3'd1:    s = {K_RD_OLD, 8'h00};
                                3'd2:    s = {K_CMD, CMD_PROG_SETUP};
                                3'd3:    s = {K_DATA, 8'h00};
                                default: s = {K_END, 8'h00};
                            endcase
            OP_ERASE:       if (i == 3'd0) s = {K_CMD, CMD_ERASE_SETUP};
                            else if (i == 3'd1) s = {K_CMD, CMD_CONFIRM};
            OP_SUSPEND:     if (i == 3'd0) s = {K_CMD, CMD_SUSPEND};
            OP_RESUME:      if (i == 3'd0) s = {K_CMD, CMD_CONFIRM};
            OP_CLEAR:       if (i == 3'd0) s = {K_CMD, CMD_CLEAR};
            default:        s = {K_END, 8'h00};
        endcase
        step_info = s;
    endfunction

    logic               aw_held_reg, w_held_reg;
    logic [7:0]         aw_addr_reg;
    logic [31:0]        w_data_reg;
    logic [3:0]         w_strb_reg;
    fch_op_e            op_reg;
    logic [ADDR_W-1:0]  addr_reg;
    logic [DATA_W-1:0]  prog_reg, old_reg, rbyte_reg;
    logic               rp_on_reg, done_reg, refused_reg;
    logic [7:0]         wake_reg, cnt_reg, cnt_next;
    logic [2:0]         step_reg, step_next;
    fch_state_e         state_reg, state_next;
    logic               rb_sync1_reg, rb_sync2_reg;
    logic [DATA_W-1:0]  dq_sync1_reg, dq_sync2_reg;
    fch_pins_s          pins_reg, pins_next;

    // AXI4-Lite write channels taken independently
    assign awready = !aw_held_reg;
    assign wready  = !w_held_reg;
    assign arready = !rvalid;
    wire do_write  = aw_held_reg && w_held_reg && !bvalid;
    wire wr_hit    = do_write && reg_mapped(aw_addr_reg);
    wire wr_ctrl   = wr_hit && (aw_addr_reg == REG_CTRL) && w_strb_reg[0];
    wire wr_addr   = wr_hit && (aw_addr_reg == REG_ADDR);
    wire wr_wdata  = wr_hit && (aw_addr_reg == REG_WDATA) && w_strb_reg[0];
    wire wr_power  = wr_hit && (aw_addr_reg == REG_POWER) && w_strb_reg[0];
    wire [31:0] addr_merged = merge({12'h000, addr_reg}, w_data_reg, w_strb_reg);

    // Operation acceptance
    wire fch_op_e op_req   = fch_op_e'(w_data_reg[3:0]);
    wire op_valid          = (w_data_reg[3:0] <= OP_CLEAR);
    wire rp_on_next        = wr_power ? w_data_reg[0] : rp_on_reg;
    wire read_ok           = rp_on_reg && (wake_reg >= WAKE_READ_CNT);
    wire write_ok          = rp_on_reg && (wake_reg >= WAKE_WRITE_CNT);
    wire window_ok         = (op_req == OP_READ) ? read_ok : write_ok;
    wire accept            = wr_ctrl && (state_reg == ST_IDLE) && op_valid && window_ok;
    wire refuse            = wr_ctrl && !accept;

    // Current step decode
    wire [10:0] info       = step_info(op_reg, step_reg);
    wire fch_kind_e kind   = fch_kind_e'(info[10:8]);
    wire [DATA_W-1:0] wr_byte = (kind == K_DATA) ? (prog_reg | ~old_reg) : info[7:0];
    wire [ADDR_W-1:0] blk_addr = {addr_reg[ADDR_W-1:BLOCK_LSB], {BLOCK_LSB{1'b0}}};
    wire [ADDR_W-1:0] id_addr  = {{(ADDR_W-1){1'b0}}, addr_reg[0]};
    wire [ADDR_W-1:0] op_addr  = (op_reg == OP_ERASE) ? blk_addr :
                                 (op_reg == OP_READ_ID) ? id_addr : addr_reg;
    wire last_cnt          = (cnt_reg == CNT_ONE);
    wire capture           = (state_reg == ST_READ) && last_cnt;

    // Register read mux
    wire [31:0] status_word = {26'h0000000, write_ok, read_ok, rb_sync2_reg,
                               refused_reg, done_reg, (state_reg != ST_IDLE)};
    wire [31:0] rd_mux =
        (araddr == REG_CTRL)   ? {28'h0000000, op_reg} :
        (araddr == REG_ADDR)   ? {12'h000, addr_reg} :
        (araddr == REG_WDATA)  ? {24'h000000, prog_reg} :
        (araddr == REG_POWER)  ? {31'h00000000, rp_on_reg} :
        (araddr == REG_STATUS) ? status_word :
        (araddr == REG_RDATA)  ? {24'h000000, rbyte_reg} : 32'h00000000;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        step_next  = step_reg;
        case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    state_next = ST_NEXT;
                    step_next  = 3'd0;
                end
            end
            ST_NEXT: begin
                if (kind == K_END) begin
                    state_next = ST_IDLE;
                end else if (kind == K_RD || kind == K_RD_OLD) begin
                    state_next = ST_READ;
                    cnt_next   = READ_CNT;
                end else begin
                    state_next = ST_SETUP;
                end
            end
            ST_SETUP: begin
                state_next = ST_PULSE;
                cnt_next   = WE_LOW_CNT;
            end
            ST_PULSE: begin
                if (last_cnt) begin
                    state_next = ST_HOLD;
                end else begin
                    cnt_next = cnt_reg - CNT_ONE;
                end
            end
            ST_HOLD: begin
                state_next = ST_NEXT;
                step_next  = step_reg + 3'd1;
            end
            ST_READ: begin
                if (last_cnt) begin
                    state_next = ST_NEXT;
                    step_next  = step_reg + 3'd1;
                end else begin
                    cnt_next = cnt_reg - CNT_ONE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (!rp_on_next) begin
            state_next = ST_IDLE;
        end
    end

    always_comb begin
        pins_next                   = PINS_RESET;
        pins_next.reset_powerdown_n = rp_on_next;
        pins_next.ce_n              = (state_next == ST_IDLE) || (state_next == ST_NEXT);
        pins_next.oe_n              = (state_next != ST_READ);
        pins_next.we_n              = (state_next != ST_PULSE);
        pins_next.data_bus_oe_n     = !((state_next == ST_SETUP) || (state_next == ST_PULSE) ||
                                        (state_next == ST_HOLD));
        pins_next.addr              = op_addr;
        pins_next.data_bus_out      = wr_byte;
    end
    assign flash_pins = pins_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
            bvalid      <= 1'b0;
            bresp       <= RESP_OKAY;
            rvalid      <= 1'b0;
            rresp       <= RESP_OKAY;
            rdata       <= 32'h00000000;
        end else begin
            if (awvalid && awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= awaddr;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
            if (do_write) begin
                bvalid <= 1'b1;
                bresp  <= reg_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata  <= rd_mux;
                rresp  <= reg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op_reg      <= OP_READ;
            addr_reg    <= 20'h00000;
            prog_reg    <= 8'hff;
            old_reg     <= 8'hff;
            rbyte_reg   <= 8'h00;
            rp_on_reg   <= 1'b0;
            done_reg    <= 1'b0;
            refused_reg <= 1'b0;
            wake_reg    <= 8'h00;
            cnt_reg     <= 8'h00;
            step_reg    <= 3'd0;
            state_reg   <= ST_IDLE;
            pins_reg    <= PINS_RESET;
        end else begin
            if (accept) begin
                op_reg <= op_req;
            end
            if (wr_addr) begin
                addr_reg <= addr_merged[ADDR_W-1:0];
            end
            if (wr_wdata) begin
                prog_reg <= w_data_reg[DATA_W-1:0];
            end
            rp_on_reg   <= rp_on_next;
            done_reg    <= (state_reg == ST_NEXT && kind == K_END) || (done_reg && !accept);
            refused_reg <= refuse || (refused_reg && !accept);
            if (!rp_on_reg) begin
                wake_reg <= 8'h00;
            end else if (wake_reg != WAKE_WRITE_CNT) begin
                wake_reg <= wake_reg + CNT_ONE;
            end
            if (capture && kind == K_RD) begin
                rbyte_reg <= dq_sync2_reg;
            end
            if (capture && kind == K_RD_OLD) begin
                old_reg <= dq_sync2_reg;
            end
            cnt_reg   <= cnt_next;
            step_reg  <= step_next;
            state_reg <= state_next;
            pins_reg  <= pins_next;
        end
    end

    // Pin synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rb_sync1_reg <= 1'b1;
            rb_sync2_reg <= 1'b1;
            dq_sync1_reg <= 8'h00;
            dq_sync2_reg <= 8'h00;
        end else begin
            rb_sync1_reg <= ready_busy_n;
            rb_sync2_reg <= rb_sync1_reg;
            dq_sync1_reg <= data_bus_in;
            dq_sync2_reg <= dq_sync1_reg;
        end
    end

endmodule // fch_ctrl

// >>> fch_pkg.sv
// Shared constants and types for the flash command sequencer.
// Assumes a 25 MHz aclk; the flash pins are driven from registers.
package fch_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS  = 40;
    localparam int WAKE_READ_NS   = 400;
    localparam int WAKE_WRITE_NS  = 1000;
    localparam int WE_LOW_NS      = 80;
    localparam int READ_ACCESS_NS = 120;
    localparam int SYNC_CYC       = 2;
    localparam logic [7:0] WAKE_READ_CNT  =
        8'((WAKE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WAKE_WRITE_CNT =
        8'((WAKE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WE_LOW_CNT     =
        8'((WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] READ_CNT       =
        8'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC + 1);
    localparam logic [7:0] CNT_ONE        = 8'h01;

    // Widths
    localparam int ADDR_W   = 20;
    localparam int DATA_W   = 8;
    localparam int BLOCK_LSB = 16;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_POWER  = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RDATA  = 8'h14;

    // Status bit positions
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_DONE_BIT    = 1;
    localparam int ST_REFUSED_BIT = 2;
    localparam int ST_FREADY_BIT  = 3;
    localparam int ST_RD_OK_BIT   = 4;
    localparam int ST_WR_OK_BIT   = 5;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Flash command bytes
    localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_ID     = 8'h90;
    localparam logic [7:0] CMD_CLEAR       = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM     = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND     = 8'hb0;
    localparam logic [7:0] CMD_PROG_SETUP  = 8'h40;

    typedef enum logic [3:0] {
        OP_READ        = 4'h0,
        OP_READ_ARRAY  = 4'h1,
        OP_READ_STATUS = 4'h2,
        OP_READ_ID     = 4'h3,
        OP_PROGRAM     = 4'h4,
        OP_ERASE       = 4'h5,
        OP_SUSPEND     = 4'h6,
        OP_RESUME      = 4'h7,
        OP_CLEAR       = 4'h8
    } fch_op_e;

    typedef enum logic [2:0] {
        K_END    = 3'h0,
        K_CMD    = 3'h1,
        K_DATA   = 3'h2,
        K_RD     = 3'h3,
        K_RD_OLD = 3'h4
    } fch_kind_e;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_NEXT  = 6'h02,
        ST_SETUP = 6'h04,
        ST_PULSE = 6'h08,
        ST_HOLD  = 6'h10,
        ST_READ  = 6'h20
    } fch_state_e;

    typedef struct packed {
        logic              reset_powerdown_n;
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data_bus_out;
        logic              data_bus_oe_n;
    } fch_pins_s;

    localparam fch_pins_s PINS_RESET = '{
        reset_powerdown_n: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
        addr: 20'h00000, data_bus_out: 8'h00, data_bus_oe_n: 1'b1};

endpackage

// >>> fch_ctrl_props.sv
// Checker on the flash pins of fch_ctrl.
// Assumes a bind into fch_ctrl, one aclk domain.
`timescale 1ns/100ps
module fch_ctrl_props (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire fch_pkg::fch_pins_s flash_pins
);
    import fch_pkg::*;
    logic [7:0] up_cnt;
    fch_pins_s  p;
    assign p = flash_pins;
    always_ff @(posedge aclk) begin
        if (!aresetn || !p.reset_powerdown_n)
            up_cnt <= 8'h00;
        else if (up_cnt != 8'hff)
            up_cnt <= up_cnt + CNT_ONE;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_read_pins: assert property (!p.oe_n |-> !p.ce_n && p.we_n && p.data_bus_oe_n)
        else $error("read strobe with bad select");
    chk_write_pins: assert property (!p.we_n |-> !p.ce_n && p.oe_n && !p.data_bus_oe_n)
        else $error("write strobe with bad select");
    chk_read_wake: assert property (!p.oe_n |-> up_cnt >= WAKE_READ_CNT)
        else $error("read too soon after wake");
    chk_write_wake: assert property (!p.we_n |-> up_cnt >= WAKE_WRITE_CNT)
        else $error("write too soon after wake");
    chk_we_pulse: assert property (disable iff (!aresetn || !p.reset_powerdown_n)
        $fell(p.we_n) |=> !p.we_n ##1 p.we_n) else $error("write pulse length wrong");
    chk_latch_held: assert property (p.reset_powerdown_n && $rose(p.we_n)
        |-> $stable(p.addr) && $stable(p.data_bus_out) && !p.data_bus_oe_n)
        else $error("address or data moved at strobe rise");
    chk_read_span: assert property (disable iff (!aresetn || !p.reset_powerdown_n)
        $fell(p.oe_n) |-> !p.oe_n [*6] ##1 p.oe_n) else $error("read strobe length wrong");
    chk_sleep_quiet: assert property (!p.reset_powerdown_n |-> p.ce_n && p.oe_n && p.we_n)
        else $error("strobes active in power-down");
    chk_cycle_gap: assert property ($rose(p.we_n) |=> p.ce_n)
        else $error("no deselect between writes");
endmodule // fch_ctrl_props
bind fch_ctrl fch_ctrl_props u_props (.aclk(aclk), .aresetn(aresetn), .flash_pins(flash_pins));

// >>> fch_flash_model.sv
// Behavioural flash device for the sequencer bench.
// Assumes the controller's registered pins, sampled on aclk.
`timescale 1ns/100ps
module fch_flash_model #(
    parameter int         BUSY_CYC    = 40,
    // Arbitrary identifier codes
    parameter logic [7:0] MAKER_CODE  = 8'h5a,
    parameter logic [7:0] DEVICE_CODE = 8'h3c,
    parameter bit         SUPPLY_HIGH = 1'b1
) (
    input  wire logic               aclk,
    input  wire fch_pkg::fch_pins_s pins,
    output logic [7:0]              data_bus,
    output logic                    ready_busy_n,
    output int                      twice_zero
);
    import fch_pkg::*;
    logic [7:0] mem [logic [19:0]];
    logic [7:0] setup_cmd = 8'h00;
    logic [7:0] float_pat = 8'h5a;
    logic [1:0] mode      = 2'd0;
    logic       we_q      = 1'b1;
    logic       susp      = 1'b0;
    int         busy_cnt  = 0;
    int         wake_cnt  = 0;
    int         zero_cnt  = 0;
    assign twice_zero = zero_cnt;
    task automatic cmd_write(input logic [19:0] a, input logic [7:0] d);
        logic [7:0] old;
        old = mem.exists(a) ? mem[a] : 8'hff;
        setup_cmd <= 8'h00;
        if (busy_cnt > 0 && !susp) begin
            if (d == CMD_SUSPEND)
                susp <= 1'b1;
        end else if (setup_cmd == CMD_PROG_SETUP) begin
            if ((~d & ~old) != 8'h00)
                zero_cnt <= zero_cnt + 1;
            if (SUPPLY_HIGH)
                mem[a] = old & d;
            busy_cnt <= BUSY_CYC;
            mode <= 2'd1;
        end else if (setup_cmd == CMD_ERASE_SETUP && d == CMD_CONFIRM) begin
            foreach (mem[k])
                if (SUPPLY_HIGH && k[19:16] == a[19:16])
                    mem[k] = 8'hff;
            busy_cnt <= BUSY_CYC;
            mode <= 2'd1;
        end else if (susp && d == CMD_CONFIRM) begin
            susp <= 1'b0;
            mode <= 2'd1;
        end else begin
            mode <= (d == CMD_READ_ARRAY) ? 2'd0 : (d == CMD_READ_ID) ? 2'd2 : 2'd1;
            if (d == CMD_ERASE_SETUP || d == CMD_PROG_SETUP)
                setup_cmd <= d;
        end
    endtask
    always @(posedge aclk) begin
        we_q <= pins.we_n;
        float_pat <= ~float_pat + 8'h01;
        if (!pins.reset_powerdown_n) begin
            mode <= 2'd0;
            busy_cnt <= 0;
            susp <= 1'b0;
            setup_cmd <= 8'h00;
            wake_cnt <= 0;
        end else begin
            wake_cnt <= wake_cnt + 1;
            if (busy_cnt > 0 && !susp)
                busy_cnt <= busy_cnt - 1;
            if (!we_q && pins.we_n && !pins.ce_n && wake_cnt >= int'(WAKE_WRITE_CNT))
                cmd_write(pins.addr, pins.data_bus_out);
        end
    end
    assign ready_busy_n = !pins.reset_powerdown_n || busy_cnt == 0 || susp;
    always @* begin
        if (pins.ce_n || pins.oe_n || !pins.reset_powerdown_n ||
            wake_cnt < int'(WAKE_READ_CNT))
            data_bus = float_pat;
        else if (mode == 2'd1)
            data_bus = {ready_busy_n, susp, 6'h00};
        else if (mode == 2'd2)
            data_bus = pins.addr[0] ? DEVICE_CODE : MAKER_CODE;
        else
            data_bus = mem.exists(pins.addr) ? mem[pins.addr] : 8'hff;
    end
endmodule // fch_flash_model

// >>> fch_ctrl_test.sv
// Self-checking bench for the flash command sequencer.
// Assumes the flash model on the controller's pins.
`timescale 1ns/100ps
module fch_ctrl_test;
    import fch_pkg::*;
    // Arbitrary identifier codes
    localparam logic [7:0] MAKER = 8'h5a;
    localparam logic [7:0] DEVID = 8'h3c;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, dq;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, rb_n;
    logic [1:0]  bresp, rresp, rs;
    fch_pins_s   pins;
    int          twice, n_mismatch = 0, checked = 0;
    fch_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .flash_pins(pins), .data_bus_in(dq),
        .ready_busy_n(rb_n));
    fch_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVID)) u_flash (.aclk(aclk),
        .pins(pins), .data_bus(dq), .ready_busy_n(rb_n), .twice_zero(twice));
    initial forever #20 aclk = ~aclk;
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic st_wait(input int bit_no);
        do rd(REG_STATUS, v, rs); while (v[bit_no] !== 1'b1);
    endtask
    task automatic run(input logic [19:0] a, input logic [3:0] c);
        wr(REG_ADDR, {12'h000, a}, rs);
        wr(REG_CTRL, {28'h0, c}, rs);
        do rd(REG_STATUS, v, rs); while (v[ST_BUSY_BIT] !== 1'b0);
    endtask
    task automatic rdb(input logic [19:0] a, input logic [3:0] c);
        run(a, c);
        rd(REG_RDATA, v, rs);
    endtask
    task automatic t_off();
        rd(REG_STATUS, v, rs);
        chk(v, 32'h8);
        wr(REG_CTRL, 32'h1, rs);
        rd(REG_STATUS, v, rs);
        chk(v, 32'hc);
    endtask
    task automatic t_wake();
        wr(REG_POWER, 32'h1, rs);
        wr(REG_CTRL, {28'h0, OP_READ}, rs);
        rd(REG_STATUS, v, rs);
        chk(v[ST_REFUSED_BIT], 1'b1);
        st_wait(ST_RD_OK_BIT);
        wr(REG_CTRL, {28'h0, OP_READ_ARRAY}, rs);
        rd(REG_STATUS, v, rs);
        chk(v[ST_REFUSED_BIT], 1'b1);
        st_wait(ST_WR_OK_BIT);
        rdb(20'h12345, OP_READ);
        chk(v, 32'hff);
        rdb(20'h00000, OP_READ_STATUS);
        chk(v, 32'h80);
        for (int i = 0; i < 2; i++) begin
            rdb(20'(i), OP_READ_ID);
            chk(v, i ? DEVID : MAKER);
        end
    endtask
    task automatic t_prog();
        wr(REG_WDATA, 32'h3c, rs);
        run(20'h12345, OP_PROGRAM);
        rd(REG_STATUS, v, rs);
        chk(v[ST_FREADY_BIT], 1'b0);
        st_wait(ST_FREADY_BIT);
        wr(REG_WDATA, 32'h0c, rs);
        run(20'h12345, OP_PROGRAM);
        st_wait(ST_FREADY_BIT);
        wr(REG_WDATA, 32'h5a, rs);
        run(20'h23456, OP_PROGRAM);
        st_wait(ST_FREADY_BIT);
        rdb(20'h12345, OP_READ_ARRAY);
        chk(v, 32'h0c);
        chk(32'(twice), 32'h0);
    endtask
    task automatic t_erase();
        run(20'h1ffff, OP_ERASE);
        run(20'h00000, OP_SUSPEND);
        st_wait(ST_FREADY_BIT);
        rdb(20'h23456, OP_READ_ARRAY);
        chk(v, 32'h5a);
        run(20'h00000, OP_RESUME);
        rd(REG_STATUS, v, rs);
        chk(v[ST_FREADY_BIT], 1'b0);
        st_wait(ST_FREADY_BIT);
        rdb(20'h12345, OP_READ_ARRAY);
        chk(v, 32'hff);
        rdb(20'h23456, OP_READ_ARRAY);
        chk(v, 32'h5a);
    endtask
    task automatic t_misc();
        wr(REG_CTRL, 32'h9, rs);
        rd(REG_STATUS, v, rs);
        chk(v[ST_REFUSED_BIT], 1'b1);
        rd(8'h18, v, rs);
        chk(rs, RESP_SLVERR);
        wr(8'h18, 32'h1, rs);
        chk(rs, RESP_SLVERR);
        run(20'h23456, OP_ERASE);
        wr(REG_POWER, 32'h0, rs);
        chk(pins.reset_powerdown_n, 1'b0);
        rd(REG_STATUS, v, rs);
        chk(v[ST_FREADY_BIT], 1'b1);
        wr(REG_POWER, 32'h1, rs);
        st_wait(ST_WR_OK_BIT);
        rdb(20'h00000, OP_READ_STATUS);
        chk(v, 32'h80);
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_off();
        t_wake();
        t_prog();
        t_erase();
        t_misc();
        stop_test();
    end
    initial begin
        #400000;
        n_mismatch++;
        stop_test();
    end
endmodule // fch_ctrl_test
